//--- hw/msc_pkg.sv
// Shared constants and carrier types of the motor starter parameter bank.
package msc_pkg;

  // Parameter indices of each register.
  localparam logic [15:0] IDX_LANG    = 16'h3440;
  localparam logic [15:0] IDX_LED     = 16'h3700;
  localparam logic [15:0] IDX_CONT    = 16'h3740;
  localparam logic [15:0] IDX_BLIGHT  = 16'h3780;
  localparam logic [15:0] IDX_TIME_HI = 16'h3980;
  localparam logic [15:0] IDX_TIME_MD = 16'h3981;
  localparam logic [15:0] IDX_TIME_LO = 16'h3982;
  localparam logic [15:0] IDX_WDOG    = 16'h3dc0;
  localparam logic [15:0] IDX_STATION = 16'h3e80;
  localparam logic [15:0] IDX_BAUD    = 16'h3ec0;
  localparam logic [15:0] IDX_PARITY  = 16'h3f00;
  localparam logic [15:0] IDX_RUN     = 16'h4600;
  localparam logic [15:0] IDX_HOLD    = 16'h4740;
  localparam logic [15:0] IDX_FCLR    = 16'h47c0;

  // Reset values.
  localparam logic [15:0] RST_LANG    = 16'h0001;
  localparam logic        RST_LED     = 1'b0;
  localparam logic        RST_CONT    = 1'b0;
  localparam logic [15:0] RST_BLIGHT  = 16'h003c;
  localparam logic [15:0] RST_WDOG    = 16'h1388;
  localparam logic [15:0] RST_STATION = 16'h0001;
  localparam logic [15:0] RST_BAUD    = 16'h0001;
  localparam logic [15:0] RST_PARITY  = 16'h0001;
  localparam logic        RST_CMD     = 1'b0;

  // Legal value ranges.
  localparam logic [15:0] LANG_MIN    = 16'h0001;
  localparam logic [15:0] LANG_MAX    = 16'h000d;
  localparam logic [15:0] BOOL_MAX    = 16'h0001;
  localparam logic [15:0] BLIGHT_MAX  = 16'h0e10;
  localparam logic [15:0] WDOG_MAX    = 16'hea60;
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h0020;
  localparam logic [15:0] BAUD_MAX    = 16'h0004;
  localparam logic [15:0] PARITY_MAX  = 16'h0002;
  localparam logic [1:0]  PARITY_NONE = 2'h0;

  // Timing: clock period, one millisecond, one second, one day.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0]  MS_PER_S      = 10'h3e8;
  localparam logic [31:0] MS_PER_DAY    = 32'h0526_5c00;

  // Bit period in clock cycles per bit rate code 0 to 4.
  localparam logic [15:0] DIV_9600   = 16'h28b1;
  localparam logic [15:0] DIV_19200  = 16'h1458;
  localparam logic [15:0] DIV_38400  = 16'h0a2c;
  localparam logic [15:0] DIV_57600  = 16'h06c8;
  localparam logic [15:0] DIV_115200 = 16'h0364;

  // One parameter access from the serial front end.
  typedef struct packed {
    logic        write;
    logic [7:0]  station;
    logic [15:0] index;
    logic [15:0] wdata;
  } msc_req_t;

  // Answer to a taken access.
  typedef struct packed {
    logic        err;
    logic [15:0] rdata;
  } msc_rsp_t;

endpackage

//--- hw/msc_param_bank.sv
// Parameter bank, watchdog, clock and backlight of the motor starter.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Hold language code 1 to 13, default 1.
// - LED traffic mode shows receive red, transmit green.
// - Contactor control masks faults with zero stop.
// - Backlight off after timeout seconds; zero disables.
// - Touch relights backlight and restarts timeout.
// - Six-byte time: milliseconds then day count.
// - Time defaults GMT and is writable.
// - Trip when no access within watchdog period.
// - Answer only own station number 1 to 32.
// - Bit rate code 0 to 4 sets baud.
// - Parity code none, even, odd; default even.
// - No parity uses two stop bits.
// - Run command starts or stops the motor.
// - Ramp hold command freezes the start ramp.
// - Ramp hold applies even below current limit.
// - Fault reset only on high then low.
module msc_param_bank
  import msc_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        req_valid_in,
  input  wire msc_req_t    req_in,
  output logic             ack_out,
  output msc_rsp_t         rsp_out,
  input  wire logic        rx_activity_in,
  input  wire logic        tx_activity_in,
  input  wire logic        status_red_in,
  input  wire logic        status_green_in,
  output logic             led_red_out,
  output logic             led_green_out,
  input  wire logic        contactor_open_in,
  input  wire logic        stop_time_zero_in,
  output logic             fault_mask_out,
  input  wire logic        touch_in,
  output logic             backlight_on_out,
  input  wire logic        comm_trip_enable_in,
  output logic             comm_trip_out,
  output logic [15:0]      language_out,
  output logic [7:0]       station_out,
  output logic [15:0]      bit_period_out,
  output logic [1:0]       parity_out,
  output logic             two_stop_out,
  output logic [47:0]      time_out,
  output logic             run_out,
  output logic             ramp_hold_out,
  output logic             fault_reset_out
);

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [15:0] lang_ff;
  logic        led_sel_ff;
  logic        cont_ff;
  logic [15:0] blight_ff;
  logic [15:0] wdog_ff;
  logic [15:0] station_ff;
  logic [15:0] baud_ff;
  logic [15:0] parity_ff;
  logic        run_ff;
  logic        hold_ff;
  logic        fclr_ff;
  logic [31:0] ms_ff;
  logic [15:0] day_ff;
  logic [31:0] pre_ff;
  logic [9:0]  sec_pre_ff;
  logic [11:0] bl_cnt_ff;
  logic        bl_on_ff;
  logic [15:0] wd_cnt_ff;
  logic        trip_ff;
  logic        ack_ff;
  msc_rsp_t    rsp_ff;
  logic        red_ff;
  logic        green_ff;
  logic        mask_ff;
  logic [15:0] div_ff;
  logic        pulse_ff;

  // Reset is released through two flops so its removal is clean.
  // Only the second flop feeds the rest of the bank; the raw pin still
  // asserts at once, so a lost clock cannot hold stale settings.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // An access is taken only when it names this station.
  // Requests for other stations leave the watchdog running, since that
  // traffic was never meant for this unit.
  wire        taken = req_valid_in && (req_in.station == station_ff[7:0]);
  wire        wr    = taken && req_in.write;
  wire [15:0] wd    = req_in.wdata;
  wire [15:0] idx   = req_in.index;

  // Address decode. The clock value sits at three adjacent indices,
  // high millisecond word first, then low word, then the day count.
  // Each word is written on its own, so software should load them while
  // no millisecond tick can carry between the two halves.
  wire hit_lang    = idx == IDX_LANG;
  wire hit_led     = idx == IDX_LED;
  wire hit_cont    = idx == IDX_CONT;
  wire hit_blight  = idx == IDX_BLIGHT;
  wire hit_thi     = idx == IDX_TIME_HI;
  wire hit_tmd     = idx == IDX_TIME_MD;
  wire hit_tlo     = idx == IDX_TIME_LO;
  wire hit_wdog    = idx == IDX_WDOG;
  wire hit_station = idx == IDX_STATION;
  wire hit_baud    = idx == IDX_BAUD;
  wire hit_parity  = idx == IDX_PARITY;
  wire hit_run     = idx == IDX_RUN;
  wire hit_hold    = idx == IDX_HOLD;
  wire hit_fclr    = idx == IDX_FCLR;
  wire hit_bool    = hit_led | hit_cont | hit_run | hit_hold | hit_fclr;
  wire hit_time    = hit_thi | hit_tmd | hit_tlo;
  wire mapped      = hit_lang | hit_bool | hit_blight | hit_time | hit_wdog |
                     hit_station | hit_baud | hit_parity;

  // Range check; a failing write leaves the register untouched.
  // The answer still comes, flagged as an error, so the master is never
  // left waiting on a rejected value.
  wire in_range =
    (hit_lang & (wd >= LANG_MIN) & (wd <= LANG_MAX)) |
    (hit_bool & (wd <= BOOL_MAX)) |
    (hit_blight & (wd <= BLIGHT_MAX)) |
    (hit_wdog & (wd <= WDOG_MAX)) |
    (hit_station & (wd >= STATION_MIN) & (wd <= STATION_MAX)) |
    (hit_baud & (wd <= BAUD_MAX)) |
    (hit_parity & (wd <= PARITY_MAX)) |
    hit_time;
  wire wr_ok  = wr && in_range;
  wire req_err = !mapped || (taken && req_in.write && !in_range);

  // Read data selection.
  // One-bit settings read back as 0 or 1 in the low bit.
  wire [15:0] rd_mux =
    hit_lang    ? lang_ff :
    hit_led     ? {15'h0000, led_sel_ff} :
    hit_cont    ? {15'h0000, cont_ff} :
    hit_blight  ? blight_ff :
    hit_thi     ? ms_ff[31:16] :
    hit_tmd     ? ms_ff[15:0] :
    hit_tlo     ? day_ff :
    hit_wdog    ? wdog_ff :
    hit_station ? station_ff :
    hit_baud    ? baud_ff :
    hit_parity  ? parity_ff :
    hit_run     ? {15'h0000, run_ff} :
    hit_hold    ? {15'h0000, hold_ff} :
    hit_fclr    ? {15'h0000, fclr_ff} : 16'h0000;

  // Settings registers; the station change takes effect after the answer.
  // The answer itself still goes out under the old station number, so
  // the master sees its write confirmed.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lang_ff    <= RST_LANG;
      led_sel_ff <= RST_LED;
      cont_ff    <= RST_CONT;
      blight_ff  <= RST_BLIGHT;
      wdog_ff    <= RST_WDOG;
      station_ff <= RST_STATION;
      baud_ff    <= RST_BAUD;
      parity_ff  <= RST_PARITY;
    end else begin
      if (wr_ok && hit_lang) lang_ff <= wd;
      if (wr_ok && hit_led) led_sel_ff <= wd[0];
      if (wr_ok && hit_cont) cont_ff <= wd[0];
      if (wr_ok && hit_blight) blight_ff <= wd;
      if (wr_ok && hit_wdog) wdog_ff <= wd;
      if (wr_ok && hit_station) station_ff <= wd;
      if (wr_ok && hit_baud) baud_ff <= wd;
      if (wr_ok && hit_parity) parity_ff <= wd;
    end
  end

  // Command registers. Reset fires on a 1 to 0 write of the clear command.
  // A lone write of 0 after power-up does nothing, because the stored
  // value has to be 1 first.
  wire fclr_fall = wr_ok && hit_fclr && fclr_ff && !wd[0];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_ff   <= RST_CMD;
      hold_ff  <= RST_CMD;
      fclr_ff  <= RST_CMD;
      pulse_ff <= 1'b0;
    end else begin
      if (wr_ok && hit_run) run_ff <= wd[0];
      if (wr_ok && hit_hold) hold_ff <= wd[0];
      if (wr_ok && hit_fclr) fclr_ff <= wd[0];
      pulse_ff <= fclr_fall;
    end
  end

  // Millisecond prescaler shared by clock, backlight and watchdog.
  // It runs free, so a timer that starts between ticks counts its first
  // unit short; the timers below allow for this by counting one more.
  wire ms_tick  = pre_ff == 32'(CYC_MS - 1);
  wire sec_tick = ms_tick && (sec_pre_ff == MS_PER_S - 10'h001);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff     <= 32'h0000_0000;
      sec_pre_ff <= 10'h000;
    end else begin
      pre_ff <= ms_tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
      if (sec_tick) sec_pre_ff <= 10'h000;
      else if (ms_tick) sec_pre_ff <= sec_pre_ff + 10'h001;
    end
  end

  // Time of day. Starts at zero, which software treats as GMT until it
  // loads local time; a write wins over the tick in the same cycle.
  wire day_end = ms_tick && (ms_ff >= MS_PER_DAY - 32'h0000_0001);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ms_ff  <= 32'h0000_0000;
      day_ff <= 16'h0000;
    end else begin
      if (wr_ok && hit_thi) ms_ff[31:16] <= wd;
      else if (wr_ok && hit_tmd) ms_ff[15:0] <= wd;
      else if (day_end) ms_ff <= 32'h0000_0000;
      else if (ms_tick) ms_ff <= ms_ff + 32'h0000_0001;
      if (wr_ok && hit_tlo) day_ff <= wd;
      else if (day_end) day_ff <= day_ff + 16'h0001;
    end
  end

  // Backlight timer counts whole seconds of no touch. Expiry waits until
  // the count has reached the timeout, so the light goes out up to one
  // second late but never before the full period has passed.
  wire bl_expire = (blight_ff != 16'h0000) && sec_tick &&
                   ({4'h0, bl_cnt_ff} >= blight_ff);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bl_cnt_ff <= 12'h000;
      bl_on_ff  <= 1'b1;
    end else begin
      if (touch_in) begin
        bl_cnt_ff <= 12'h000;
        bl_on_ff  <= 1'b1;
      end else if (blight_ff == 16'h0000) begin
        bl_cnt_ff <= 12'h000;
        bl_on_ff  <= 1'b1;
      end else if (bl_expire) begin
        bl_on_ff <= 1'b0;
      end else if (sec_tick && bl_on_ff) begin
        bl_cnt_ff <= bl_cnt_ff + 12'h001;
      end
    end
  end

  // Watchdog: any taken access restarts it. The trip stays until a fault
  // reset; a new timeout in the reset cycle wins so none is lost.
  // A trip needs a full timeout of whole ticks with no access, so a master
  // that keeps to the period is never tripped; the cost is up to one
  // extra millisecond before a real loss of traffic is flagged.
  wire wd_expire = comm_trip_enable_in && (wdog_ff != 16'h0000) && ms_tick &&
                   (wd_cnt_ff >= wdog_ff);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= 16'h0000;
      trip_ff   <= 1'b0;
    end else begin
      if (taken || !comm_trip_enable_in || wd_expire) begin
        wd_cnt_ff <= 16'h0000;
      end else if (ms_tick) begin
        wd_cnt_ff <= wd_cnt_ff + 16'h0001;
      end
      if (wd_expire) trip_ff <= 1'b1;
      else if (pulse_ff) trip_ff <= 1'b0;
    end
  end

  // Bit period from the rate code; unknown codes cannot be stored.
  wire [15:0] div_sel =
    (baud_ff == 16'h0000) ? DIV_9600 :
    (baud_ff == 16'h0001) ? DIV_19200 :
    (baud_ff == 16'h0002) ? DIV_38400 :
    (baud_ff == 16'h0003) ? DIV_57600 : DIV_115200;

  // Traffic_led_select and fault masking are registered to keep outputs clean.
  // The one-cycle lag is far below what an eye or a relay can notice.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      red_ff   <= 1'b0;
      green_ff <= 1'b0;
      mask_ff  <= 1'b0;
      div_ff   <= DIV_19200;
    end else begin
      red_ff   <= led_sel_ff ? rx_activity_in : status_red_in;
      green_ff <= led_sel_ff ? tx_activity_in : status_green_in;
      mask_ff  <= cont_ff && stop_time_zero_in && contactor_open_in;
      div_ff   <= div_sel;
    end
  end

  // Answer one cycle after the access is taken.
  // Writes answer with zero data; the response holds until the next one.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      ack_ff <= taken;
      if (taken) begin
        rsp_ff.err   <= req_err;
        rsp_ff.rdata <= req_in.write ? 16'h0000 : rd_mux;
      end
    end
  end

  // Outputs. The ramp hold does not look at motor current at all.
  // Stop-bit count follows parity alone, so the two can never disagree.
  assign ack_out          = ack_ff;
  assign rsp_out          = rsp_ff;
  assign led_red_out      = red_ff;
  assign led_green_out    = green_ff;
  assign fault_mask_out   = mask_ff;
  assign backlight_on_out = bl_on_ff;
  assign comm_trip_out    = trip_ff;
  assign language_out     = lang_ff;
  assign station_out      = station_ff[7:0];
  assign bit_period_out   = div_ff;
  assign parity_out       = parity_ff[1:0];
  assign two_stop_out     = parity_ff[1:0] == PARITY_NONE;
  assign time_out         = {ms_ff, day_ff};
  assign run_out          = run_ff;
  assign ramp_hold_out    = hold_ff;
  assign fault_reset_out  = pulse_ff;

endmodule

`default_nettype wire

//--- bench/msc_param_bank_checker.sv
// Assertion checker that watches the parameter bank ports.
`timescale 1ns/1ps
`default_nettype none
module msc_param_bank_checker
  import msc_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        req_valid_in,
  input wire msc_req_t    req_in,
  input wire logic        ack_out,
  input wire logic        contactor_open_in,
  input wire logic        stop_time_zero_in,
  input wire logic        fault_mask_out,
  input wire logic        comm_trip_enable_in,
  input wire logic        comm_trip_out,
  input wire logic [15:0] language_out,
  input wire logic [7:0]  station_out,
  input wire logic [1:0]  parity_out,
  input wire logic        two_stop_out,
  input wire logic        fault_reset_out
);
  // All checks share the core clock and pause while reset is applied.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // A request for this station is answered one cycle later; others never.
  property p_ack_own;
    req_valid_in && req_in.station == station_out |=> ack_out; endproperty
  a_ack_own: assert property (p_ack_own) else $error("no answer");
  property p_ack_other;
    req_valid_in && req_in.station != station_out |=> !ack_out; endproperty
  a_ack_other: assert property (p_ack_other) else $error("foreign");
  // Faults are masked only with an open contactor and a zero stop time.
  property p_mask;
    fault_mask_out |-> $past(contactor_open_in) && $past(stop_time_zero_in);
  endproperty
  a_mask: assert property (p_mask) else $error("mask cause");
  // The reset pulse follows only a taken write of 0 to the clear command.
  property p_rst_src;
    fault_reset_out |-> ack_out && $past(req_in.write) &&
      $past(req_in.index) == IDX_FCLR && !$past(req_in.wdata[0]); endproperty
  a_rst_src: assert property (p_rst_src) else $error("pulse cause");
  property p_rst_once;
    fault_reset_out |=> !fault_reset_out; endproperty
  a_rst_once: assert property (p_rst_once) else $error("long pulse");
  // A trip stays until a reset pulse, and only arises while enabled.
  property p_trip_hold;
    comm_trip_out && !fault_reset_out |=> comm_trip_out; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip lost");
  property p_trip_en;
    $rose(comm_trip_out) |-> $past(comm_trip_enable_in); endproperty
  a_trip_en: assert property (p_trip_en) else $error("trip cause");
  // Framing and stored codes never leave their legal sets.
  property p_two_stop;
    two_stop_out == (parity_out == PARITY_NONE); endproperty
  a_two_stop: assert property (p_two_stop) else $error("stop bits");
  property p_lang;
    language_out inside {[16'h0001:16'h000d]}; endproperty
  a_lang: assert property (p_lang) else $error("language code");
  property p_station;
    station_out inside {[8'h01:8'h20]} && parity_out != 2'h3; endproperty
  a_station: assert property (p_station) else $error("code");
endmodule

// Attach the checker to every bank instance.
bind msc_param_bank msc_param_bank_checker #(.CYC_MS(CYC_MS)) u_chk (
  .core_clk_in, .resetn_in, .req_valid_in, .req_in, .ack_out,
  .contactor_open_in, .stop_time_zero_in, .fault_mask_out,
  .comm_trip_enable_in, .comm_trip_out, .language_out, .station_out,
  .parity_out, .two_stop_out, .fault_reset_out
);
`default_nettype wire

//--- bench/msc_master_model.sv
// Serial network master model that issues parameter accesses.
`timescale 1ns/1ps
`default_nettype none
module msc_master_model
  import msc_pkg::*;
(
  input  wire logic     core_clk_in,
  input  wire logic     ack_in,
  input  wire msc_rsp_t rsp_in,
  output logic          req_valid_out,
  output msc_req_t      req_out
);
  // The bus starts idle with no request.
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // One access is a single-cycle request; fields are inverted afterwards
  // so that no answer can lean on stale request values.
  task automatic access(input logic wr, input logic [7:0] stn,
    input logic [15:0] idx, input logic [15:0] wd,
    output logic got, output msc_rsp_t rsp);
    int n;
    got = 1'b0;
    rsp = '0;
    @(negedge core_clk_in);
    req_out = {wr, stn, idx, wd};
    req_valid_out = 1'b1;
    @(negedge core_clk_in);
    req_valid_out = 1'b0;
    req_out = ~req_out;
    for (n = 0; n < 4 && !got; n++) begin
      if (ack_in === 1'b1) begin
        got = 1'b1;
        rsp = rsp_in;
      end else begin
        @(negedge core_clk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

//--- bench/motor_starter_comms_params_tb.sv
// Self-checking bench of the motor starter parameter bank.
`timescale 1ns/1ps
`default_nettype none
module motor_starter_comms_params_tb
  import msc_pkg::*;
();
  logic        clk, rstn, rv, ack, rx, tx, sred, sgrn, lred, lgrn, copen;
  logic        szero, fmask, touch, blon, tren, trip, two, run, hold, frst;
  logic [15:0] lang, bper;
  logic [7:0]  stn, cur_stn;
  logic [1:0]  par;
  logic [47:0] tm;
  msc_req_t    req;
  msc_rsp_t    rsp;
  int          mismatches, checks, pulses, i;
  // Rejected writes: index, illegal value, reset value that must remain.
  logic [15:0] bidx [13] = '{IDX_LANG, IDX_LANG, IDX_LED, IDX_CONT,
    IDX_BLIGHT, IDX_WDOG, IDX_STATION, IDX_STATION, IDX_BAUD, IDX_PARITY,
    IDX_RUN, IDX_HOLD, IDX_FCLR};
  logic [15:0] bval [13] = '{16'h0000, 16'h000e, 16'h0002, 16'h0002,
    16'h0e11, 16'hea61, 16'h0000, 16'h0021, 16'h0005, 16'h0003, 16'h0002,
    16'h0002, 16'h0002};
  logic [15:0] bdef [13] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h003c, 16'h1388, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000,
    16'h0000, 16'h0000};
  logic [15:0] divs [5] = '{DIV_9600, DIV_19200, DIV_38400, DIV_57600,
    DIV_115200};

  // A short millisecond keeps the second-based tests within the run.
  msc_master_model mst (.core_clk_in(clk), .ack_in(ack), .rsp_in(rsp),
    .req_valid_out(rv), .req_out(req));
  msc_param_bank #(.CYC_MS(10)) dut (.core_clk_in(clk), .resetn_in(rstn),
    .req_valid_in(rv), .req_in(req), .ack_out(ack), .rsp_out(rsp),
    .rx_activity_in(rx), .tx_activity_in(tx), .status_red_in(sred),
    .status_green_in(sgrn), .led_red_out(lred), .led_green_out(lgrn),
    .contactor_open_in(copen), .stop_time_zero_in(szero),
    .fault_mask_out(fmask), .touch_in(touch), .backlight_on_out(blon),
    .comm_trip_enable_in(tren), .comm_trip_out(trip), .language_out(lang),
    .station_out(stn), .bit_period_out(bper), .parity_out(par),
    .two_stop_out(two), .time_out(tm), .run_out(run),
    .ramp_hold_out(hold), .fault_reset_out(frst));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count fault reset pulses as they are driven.
  always @(posedge clk) if (frst === 1'b1) pulses++;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one observed value with its expectation and count both.
  task automatic chk(input string nm, input logic [47:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write, expect the given error flag, then let derived outputs settle.
  task automatic wr(input logic [15:0] idx, wd, input logic eerr);
    logic g;
    msc_rsp_t r;
    mst.access(1'b1, cur_stn, idx, wd, g, r);
    chk("write answer", {g, r.err}, {1'b1, eerr});
    repeat (2) @(negedge clk);
  endtask
  // Read and expect a clean answer carrying this data.
  task automatic rd(input logic [15:0] idx, exp);
    logic g;
    msc_rsp_t r;
    mst.access(1'b0, cur_stn, idx, 16'h0000, g, r);
    chk("read answer", {g, r.err, r.rdata}, {2'b10, exp});
  endtask

  // Main sequence of tests.
  initial begin
    logic g;
    msc_rsp_t r;
    {rstn, rx, tx, sred, sgrn, copen, szero, touch, tren} = '0;
    cur_stn = 8'h01;
    repeat (12) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 13; i++) begin
      rd(bidx[i], bdef[i]);
      wr(bidx[i], bval[i], 1'b1);
      rd(bidx[i], bdef[i]);
    end
    wr(16'h3441, 16'h0000, 1'b1);
    $display("test reset and ranges done");
    for (i = 0; i < 5; i++) begin
      wr(IDX_BAUD, 16'(i), 1'b0);
      chk("bit period", bper, divs[i]);
    end
    for (i = 0; i < 3; i++) begin
      wr(IDX_PARITY, 16'(i), 1'b0);
      chk("parity", {par, two}, {2'(i), i == 0});
    end
    wr(IDX_LANG, 16'h000d, 1'b0);
    chk("language", lang, 16'h000d);
    wr(IDX_STATION, 16'h0020, 1'b0);
    cur_stn = 8'h20;
    mst.access(1'b0, 8'h01, IDX_LANG, 16'h0000, g, r);
    chk("foreign answer", g, 1'b0);
    rd(IDX_STATION, 16'h0020);
    $display("test serial settings done");
    {rx, tx, sred, sgrn} = 4'b1001;
    repeat (2) @(negedge clk);
    chk("status leds", {lred, lgrn}, 2'b01);
    wr(IDX_LED, 16'h0001, 1'b0);
    chk("traffic_led_select", {lred, lgrn}, 2'b10);
    {rx, tx, sred, sgrn} = 4'b0110;
    repeat (2) @(negedge clk);
    chk("traffic_led_select", {lred, lgrn}, 2'b01);
    {copen, szero} = 2'b11;
    repeat (2) @(negedge clk);
    chk("mask off", fmask, 1'b0);
    wr(IDX_CONT, 16'h0001, 1'b0);
    chk("mask on", fmask, 1'b1);
    szero = 1'b0;
    repeat (2) @(negedge clk);
    chk("mask stop", fmask, 1'b0);
    wr(IDX_RUN, 16'h0001, 1'b0);
    wr(IDX_HOLD, 16'h0001, 1'b0);
    chk("run hold", {run, hold}, 2'b11);
    wr(IDX_HOLD, 16'h0000, 1'b0);
    wr(IDX_RUN, 16'h0000, 1'b0);
    chk("run hold", {run, hold}, 2'b00);
    wr(IDX_TIME_LO, 16'h0007, 1'b0);
    chk("days", tm[15:0], 16'h0007);
    // Load the last millisecond of a day; the next tick must roll over.
    wr(IDX_TIME_HI, 16'h0526, 1'b0);
    wr(IDX_TIME_MD, 16'h5bff, 1'b0);
    repeat (12) @(negedge clk);
    chk("ms roll", tm[47:17], 31'h0000_0000);
    rd(IDX_TIME_HI, 16'h0000);
    chk("day roll", tm[15:0], 16'h0008);
    $display("test outputs and commands done");
    wr(IDX_WDOG, 16'h0005, 1'b0);
    tren = 1'b1;
    repeat (45) @(negedge clk);
    chk("trip early", trip, 1'b0);
    repeat (35) @(negedge clk);
    chk("trip", trip, 1'b1);
    tren = 1'b0;
    pulses = 0;
    wr(IDX_FCLR, 16'h0000, 1'b0);
    wr(IDX_FCLR, 16'h0001, 1'b0);
    chk("no pulse yet", pulses, 0);
    wr(IDX_FCLR, 16'h0000, 1'b0);
    chk("reset pulse", {pulses[1:0], trip}, 3'b010);
    $display("test watchdog and fault reset done");
    // Seconds may be counted on a free-running tick, so allow one second.
    wr(IDX_BLIGHT, 16'h0002, 1'b0);
    touch = 1'b1;
    @(negedge clk) touch = 1'b0;
    repeat (19900) @(negedge clk);
    chk("lit", blon, 1'b1);
    repeat (10200) @(negedge clk);
    chk("dark", blon, 1'b0);
    touch = 1'b1;
    @(negedge clk) touch = 1'b0;
    repeat (3) @(negedge clk);
    chk("relit", blon, 1'b1);
    repeat (19900) @(negedge clk);
    chk("still lit", blon, 1'b1);
    $display("test backlight done");
    end_of_test();
  end
  // Cut a hang short well after the longest expected run.
  initial begin
    #800us;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
